// [rtl/asrc_map.svh]
// Purpose: Timing constants for the asynchronous static memory host port
// Assumes: 10 MHz clock, 100 ns period
// Notes:   Times in ns; cycle counts derived (min rounds up)
`ifndef ASRC_MAP_SVH
`define ASRC_MAP_SVH
`define ASRC_CLK_PERIOD_NS 100
// Slow grade figures, worst case covers both grades
`define ASRC_READ_CYCLE_NS 70
`define ASRC_OE_ACCESS_NS 35
`define ASRC_WRITE_PULSE_NS 55
`define ASRC_WRITE_CYCLE_NS 70
`define ASRC_ADDR_TO_END_NS 60
`define ASRC_WRITE_DATA_SETUP_NS 30
`define ASRC_BYTE_TO_END_NS 60
`define ASRC_WRITE_FLOAT_DELAY_NS 25
`define ASRC_OUT_FLOAT_NS 30
`define ASRC_RETENTION_RECOVERY_DELAY_NS 70
`define ASRC_CYC(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_READ_CYC `ASRC_CYC(`ASRC_READ_CYCLE_NS)
`define ASRC_WRITE_CYC `ASRC_CYC(`ASRC_WRITE_FLOAT_DELAY_NS + `ASRC_WRITE_DATA_SETUP_NS)
`define ASRC_FLOAT_CYC `ASRC_CYC(`ASRC_OUT_FLOAT_NS)
`define ASRC_RECOVER_CYC `ASRC_CYC(`ASRC_RETENTION_RECOVERY_DELAY_NS)
`endif

// [rtl/asrc_pkg.sv]
// Purpose: Types for the static memory host controller
// Assumes: Nothing
// Notes:   Constants live in asrc_map.svh
package asrc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD,
    ST_WR_SEL,
    ST_WR,
    ST_WR_END,
    ST_TURN,
    ST_RET,
    ST_RECOVER
  } asrc_state_e;
endpackage

// [rtl/asrc_ctrl.sv]
// Purpose: Host controller for an asynchronous 1M x 16 static memory
// Assumes: 10 MHz clock; address and write data registered, control pins decoded from the registered phase; data input synchronised
// Notes:   Each phase lasts whole clock cycles, far above every timing minimum
// Function
// - Address changes only while deselected
// - Write strobe high through reads
// - Strobe low exceeds float plus setup
// - No drive while memory still drives
// - Address and select lead write end
// - Write data stable before write end
// - Byte selects low before write end
// - Deselect before entering data retention
`timescale 1ns/1ps
`include "asrc_map.svh"
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
)(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              req_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]        req_byte_en_i,
  input  wire logic              retention_req_i,
  output logic                   req_ready_o,
  output logic                   rdata_valid_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   in_retention_o,
  output logic [ADDR_W-1:0]      word_address_o,
  output logic                   chip_select_n_o,
  output logic                   chip_select_hi_o,
  output logic                   write_strobe_n_o,
  output logic                   output_gate_n_o,
  output logic                   low_byte_sel_n_o,
  output logic                   high_byte_sel_n_o,
  input  wire logic [DATA_W-1:0] shared_data_bus_i,
  output logic [DATA_W-1:0]      shared_data_bus_o,
  output logic                   shared_data_bus_oe_n_o
);
  localparam logic [3:0] READ_CYC    = 4'(`ASRC_READ_CYC);
  localparam logic [3:0] WRITE_CYC   = 4'(`ASRC_WRITE_CYC);
  localparam logic [3:0] FLOAT_CYC   = 4'(`ASRC_FLOAT_CYC);
  localparam logic [3:0] RECOVER_CYC = 4'(`ASRC_RECOVER_CYC);

  asrc_state_e       state_q, state_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [DATA_W-1:0] sync1_q, sync2_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [1:0]        ben_n_q;
  logic              write_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;

  // Decode of the phase into pin levels
  wire idle_w    = (state_q == ST_IDLE);
  wire sel_w     = (state_q == ST_RD) || (state_q == ST_WR_SEL) || (state_q == ST_WR) || (state_q == ST_WR_END);
  wire strobe_w  = (state_q == ST_WR);
  wire drive_w   = (state_q == ST_WR) || (state_q == ST_WR_END);
  wire cnt_done  = (cnt_q == 4'h0);
  wire take_w    = idle_w && req_i && !retention_req_i;
  // Read data is picked up once, on the first turnaround cycle of a read
  wire sample_w  = (state_q == ST_TURN) && (cnt_q == FLOAT_CYC) && !write_q;
  // Low select guards bits 0-7, high select bits 8-15
  wire [1:0] ben_n_w = ~req_byte_en_i;

  assign req_ready_o            = take_w;
  assign rdata_valid_o          = rvalid_q;
  assign rdata_o                = rdata_q;
  assign in_retention_o         = (state_q == ST_RET);
  assign word_address_o         = addr_q;
  assign chip_select_n_o        = ~sel_w;
  assign chip_select_hi_o       = sel_w;
  assign write_strobe_n_o       = ~strobe_w;
  assign output_gate_n_o        = ~(state_q == ST_RD);
  assign low_byte_sel_n_o       = sel_w ? ben_n_q[0] : 1'b1;
  assign high_byte_sel_n_o      = sel_w ? ben_n_q[1] : 1'b1;
  assign shared_data_bus_o      = wdata_q;
  assign shared_data_bus_oe_n_o = ~drive_w;

  // Next phase; select leads strobe by a cycle and outlasts it by a cycle
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_done ? 4'h0 : cnt_q - 4'h1;
    case (state_q)
      ST_IDLE:
      begin
        if (retention_req_i)
        begin
          state_d = ST_RET;
        end
        else if (req_i)
        begin
          state_d = req_write_i ? ST_WR_SEL : ST_RD;
          cnt_d   = req_write_i ? 4'h0 : READ_CYC;
        end
      end
      ST_RD:
      begin
        if (cnt_done)
        begin
          state_d = ST_TURN;
          cnt_d   = FLOAT_CYC;
        end
      end
      ST_WR_SEL:
      begin
        state_d = ST_WR;
        cnt_d   = WRITE_CYC;
      end
      ST_WR:
      begin
        if (cnt_done)
        begin
          state_d = ST_WR_END;
        end
      end
      ST_WR_END:
      begin
        state_d = ST_TURN;
        cnt_d   = FLOAT_CYC;
      end
      ST_TURN:
      begin
        if (cnt_done)
        begin
          state_d = ST_IDLE;
        end
      end
      ST_RET:
      begin
        if (!retention_req_i)
        begin
          state_d = ST_RECOVER;
          cnt_d   = RECOVER_CYC;
        end
      end
      ST_RECOVER:
      begin
        if (cnt_done)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Phase and counter
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Request capture; address only moves while idle and deselected
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      addr_q  <= '0;
      wdata_q <= '0;
      ben_n_q <= 2'h3;
      write_q <= 1'b0;
    end
    else if (take_w)
    begin
      addr_q  <= req_addr_i;
      wdata_q <= req_wdata_i;
      ben_n_q <= ben_n_w;
      write_q <= req_write_i;
    end
  end

  // Two-flop synchroniser on the bus; sampled only at the end of a read
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      sync1_q  <= shared_data_bus_i;
      sync2_q  <= sync1_q;
      // Sync lags two cycles, so sample after the turnaround starts
      rvalid_q <= sample_w;
      if (sample_w)
      begin
        rdata_q <= sync2_q;
      end
    end
  end

  // Checks on the pins that the host drives
  no_drive_rd_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !output_gate_n_o |-> shared_data_bus_oe_n_o && write_strobe_n_o) else $error("bus driven in read");
  we_high_rd_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_q == ST_RD) |-> write_strobe_n_o) else $error("strobe low in read");
  addr_stable_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !chip_select_n_o && !$past(chip_select_n_o) |-> $stable(word_address_o)) else $error("address moved");
  sel_before_we_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(write_strobe_n_o) |-> !$past(chip_select_n_o)) else $error("select late");
  data_setup_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(write_strobe_n_o) |-> !$past(shared_data_bus_oe_n_o) && $stable(shared_data_bus_o))
    else $error("data not set up");
  sel_after_we_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(write_strobe_n_o) |-> !chip_select_n_o) else $error("select dropped early");
  ret_desel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    in_retention_o |-> chip_select_n_o && !chip_select_hi_o) else $error("selected in retention");
  recover_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(in_retention_o) |-> chip_select_n_o [*2]) else $error("access too soon");
  read_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(output_gate_n_o) |-> !output_gate_n_o [*2]) else $error("read too short");
  // Strobe must outlast its falling cycle, as ST_WR holds it low for two cycles
  wr_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(write_strobe_n_o) |-> ##1 !write_strobe_n_o) else $error("write pulse short");
  rd_cov_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) rdata_valid_o);
  wr_cov_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(write_strobe_n_o));
  ret_cov_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $fell(in_retention_o));
endmodule

// [tb/asrc_mem_model.sv]
// Purpose: Behavioural static memory on the far side of the host port
// Assumes: Slow grade delays; 256 words kept, low address bits only
// Notes:   A lane that is not driven is shown by the bench as inverse level
`timescale 1ns/1ps
module asrc_mem_model (
  input  wire logic [19:0] word_address_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        chip_select_hi_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic        output_gate_n_i,
  input  wire logic        low_byte_sel_n_i,
  input  wire logic        high_byte_sel_n_i,
  input  wire logic [15:0] bus_i,
  output logic      [15:0] bus_o,
  output logic      [1:0]  bus_en_o
);
  logic [15:0] store_q [0:255];
  logic        sel;
  logic [1:0]  lane_on;
  // Selection and lane decode; lanes drive only in a read
  assign sel = !chip_select_n_i && chip_select_hi_i;
  assign lane_on = {2{sel && write_strobe_n_i && !output_gate_n_i}}
                 & ~{high_byte_sel_n_i, low_byte_sel_n_i};
  // Inertial delay keeps old data until the new word is valid
  assign #70 bus_o = store_q[word_address_i[7:0]];
  // Slow turn-on, quicker release
  initial bus_en_o = 2'h0;
  always @(lane_on) bus_en_o <= #(lane_on == 2'h0 ? 25 : 35) lane_on;
  // Store on the end of the write, per selected lane
  always @(posedge write_strobe_n_i)
  begin
    if (sel && !low_byte_sel_n_i) store_q[word_address_i[7:0]][7:0] <= bus_i[7:0];
    if (sel && !high_byte_sel_n_i) store_q[word_address_i[7:0]][15:8] <= bus_i[15:8];
  end
endmodule

// [tb/asrc_ctrl_tb.sv]
// Purpose: Self-checking bench for the static memory host controller
// Assumes: 10 MHz clock; memory model on the pins
// Notes:   Inputs change 10 ns after the rising edge
`timescale 1ns/1ps
module asrc_ctrl_tb;
  logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, wr = 1'b0, ret = 1'b0;
  logic [19:0] addr = 20'h0, a_pin;
  logic [15:0] wd = 16'h0, rd, hd, md, bus, last_bus = 16'h0, q;
  logic [1:0]  be = 2'h0, men;
  logic        rdy, rv, inret, csn, cshi, wen, oen, lbn, hbn, boen;
  int          num_errors = 0, check_count = 0, cyc = 0;
  asrc_ctrl uut (.clk_i(clk), .reset_n_i(rst_n), .req_i(req), .req_write_i(wr), .req_addr_i(addr),
    .req_wdata_i(wd), .req_byte_en_i(be), .retention_req_i(ret), .req_ready_o(rdy), .rdata_valid_o(rv),
    .rdata_o(rd), .in_retention_o(inret), .word_address_o(a_pin), .chip_select_n_o(csn),
    .chip_select_hi_o(cshi), .write_strobe_n_o(wen), .output_gate_n_o(oen), .low_byte_sel_n_o(lbn),
    .high_byte_sel_n_o(hbn), .shared_data_bus_i(bus), .shared_data_bus_o(hd), .shared_data_bus_oe_n_o(boen));
  asrc_mem_model mem (.word_address_i(a_pin), .chip_select_n_i(csn), .chip_select_hi_i(cshi),
    .write_strobe_n_i(wen), .output_gate_n_i(oen), .low_byte_sel_n_i(lbn), .high_byte_sel_n_i(hbn),
    .bus_i(bus), .bus_o(md), .bus_en_o(men));
  // Undriven lanes flip every cycle so a stale sample cannot match
  assign bus = !boen ? hd : {men[1] ? md[15:8] : ~last_bus[15:8], men[0] ? md[7:0] : ~last_bus[7:0]};
  always @(posedge clk) last_bus <= bus;
  initial forever #50 clk = ~clk;
  // Hang guard, far above the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request; hold keeps req up so the refusal window shows on ready
  task automatic access(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] b,
                        input logic hold);
    int n;
    int low;
    int seen_rdy;
    n = 0;
    low = 0;
    seen_rdy = 0;
    @(posedge clk);
    #10;
    req = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    be = b;
    // Ready is combinational, so judge it mid-cycle where it has settled
    @(negedge clk);
    while (rdy !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check(16'(rdy), 16'h1);
    // The next rising edge takes the request
    @(posedge clk);
    #10;
    req = hold;
    n = 0;
    if (w)
    begin
      // Write runs six cycles after the take; strobe low for two of them
      repeat (6)
      begin
        @(posedge clk);
        #10;
        low += int'(wen === 1'b0);
        seen_rdy += int'(rdy === 1'b1);
      end
      check(16'(low), 16'h2);
      check(16'(seen_rdy), 16'(hold));
      if (hold)
      begin
        // Held request is taken at the first idle edge, a repeat of the same write
        @(posedge clk);
        #10;
        req = 1'b0;
      end
    end
    else
    begin
      while (rv !== 1'b1 && n < 9)
      begin
        low += int'(oen === 1'b0);
        @(posedge clk);
        #10;
        n++;
      end
      check(16'(n), 16'h3);
      check(16'(low), 16'h2);
      q = rd;
    end
  endtask
  task automatic t_word();
    access(1'b1, 20'h00012, 16'hA5C3, 2'h3, 1'b0);
    access(1'b1, 20'h000FF, 16'h5A3C, 2'h3, 1'b0);
    access(1'b0, 20'h00012, 16'h0000, 2'h3, 1'b0);
    check(q, 16'hA5C3);
    access(1'b0, 20'h000FF, 16'h0000, 2'h3, 1'b0);
    check(q, 16'h5A3C);
    $display("word test done");
  endtask
  task automatic t_lanes();
    access(1'b1, 20'h00012, 16'h1234, 2'h1, 1'b0);
    access(1'b1, 20'h00012, 16'hBEEF, 2'h2, 1'b0);
    access(1'b1, 20'h00012, 16'hFFFF, 2'h0, 1'b0);
    access(1'b0, 20'h00012, 16'h0000, 2'h3, 1'b0);
    check(q, 16'hBE34);
    $display("lane test done");
  endtask
  // Held request is refused until the write cycle has run out
  task automatic t_busy();
    access(1'b1, 20'h00020, 16'h0F0F, 2'h3, 1'b1);
    access(1'b0, 20'h00020, 16'h0000, 2'h3, 1'b0);
    check(q, 16'h0F0F);
    $display("busy test done");
  endtask
  task automatic t_retain();
    @(posedge clk);
    #10;
    ret = 1'b1;
    req = 1'b1;
    repeat (2) @(posedge clk);
    #10;
    check(16'({inret, csn, cshi, rdy}), 16'hC);
    ret = 1'b0;
    @(posedge clk);
    #10;
    check(16'(rdy), 16'h0);
    req = 1'b0;
    access(1'b0, 20'h000FF, 16'h0000, 2'h3, 1'b0);
    check(q, 16'h5A3C);
    $display("retention test done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #10;
    check(16'({csn, cshi, wen, oen, boen}), 16'h17);
    rst_n = 1'b1;
    t_word();
    t_lanes();
    t_busy();
    t_retain();
    wrap_up();
  end
endmodule
